// *** logic/fbz_consts.vh ***
// Register offsets, reset values, field positions and fixed codes for the fan boost block.
`ifndef FBZ_CONSTS_VH
`define FBZ_CONSTS_VH

`define FBZ_ADDR_BOOST_Z1 8'h80
`define FBZ_ADDR_BOOST_Z2 8'h81
`define FBZ_ADDR_BOOST_Z3 8'h82
`define FBZ_ADDR_BOOST_Z4 8'h83
`define FBZ_ADDR_HYST_Z12 8'h84
`define FBZ_ADDR_HYST_Z34 8'h85
`define FBZ_ADDR_TRIM_Z1B 8'h8E
`define FBZ_ADDR_TRIM_Z2B 8'h8F

`define FBZ_RST_BOOST_Z12 8'h3C
`define FBZ_RST_BOOST_Z34 8'h23
`define FBZ_RST_HYST 8'h00
`define FBZ_RST_TRIM 6'h00
`define FBZ_RST_TEMP 8'h00
`define FBZ_RST_DUTY 8'h00

`define FBZ_HYST_LO_LSB 0
`define FBZ_HYST_LO_MSB 3
`define FBZ_HYST_HI_LSB 4
`define FBZ_HYST_HI_MSB 7
`define FBZ_TRIM_MSB 5

`define FBZ_BOOST_OFF 8'h80
`define FBZ_BOOST_OFF_1C 8'h7F
`define FBZ_HIGH_MASK 8'h80
`define FBZ_FULL_DUTY 8'hFF
`define FBZ_TEMP_MAX 8'h7F
`define FBZ_TEMP_MIN 8'h80
`define FBZ_READ_NONE 8'h00

`endif

// *** logic/fbz_zone_cond.v ***
// One thermal zone: boost state with hysteresis and limit errors with hysteresis.
`timescale 1ns/100ps
`include "fbz_consts.vh"

module fbz_zone_cond (
   input wire clk,
   input wire rstSyncN,
   input wire [7:0] zoneTemp,
   input wire [7:0] boostThr,
   input wire [3:0] boostHyst,
   input wire [3:0] limitHyst,
   input wire [7:0] lowLimit,
   input wire [7:0] highLimit,
   input wire fanRes1C,
   output wire boostOn,
   output reg highErr_reg,
   output reg lowErr_reg
);

   localparam BOOST_IDLE = 2'b01;
   localparam BOOST_ACTIVE = 2'b10;

   reg [1:0] boostState_reg;
   reg [1:0] boostState_next;

   // Everything is widened to ten signed bits so that a threshold plus a hysteresis never wraps.
   wire signed [9:0] tempW = {{2{zoneTemp[7]}}, zoneTemp};
   wire signed [9:0] thrW = {{2{boostThr[7]}}, boostThr};
   wire signed [9:0] highW = {{2{highLimit[7]}}, highLimit};
   wire signed [9:0] lowW = {{2{lowLimit[7]}}, lowLimit};
   wire signed [9:0] bHystW = {6'h00, boostHyst};
   wire signed [9:0] lHystW = {6'h00, limitHyst};

   // A threshold of 80h always disables, 7Fh disables only at 1 degree resolution.
   wire boostDisabled = (boostThr == `FBZ_BOOST_OFF) ||
      (fanRes1C && (boostThr == `FBZ_BOOST_OFF_1C));
   wire boostRise = !boostDisabled && (tempW > thrW);
   wire boostFall = boostDisabled || ((tempW + bHystW) < thrW);

   // Boost state machine: set above the threshold, released below it by the hysteresis or when the threshold disables boost.
   always @* begin
      boostState_next = boostState_reg;
      case (boostState_reg)
         BOOST_IDLE: begin
            if (boostRise) begin
               boostState_next = BOOST_ACTIVE;
            end
         end
         BOOST_ACTIVE: begin
            if (boostFall) begin
               boostState_next = BOOST_IDLE;
            end
         end
         default: begin
            boostState_next = BOOST_IDLE;
         end
      endcase
   end

   // Boost state register.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         boostState_reg <= BOOST_IDLE;
      end else begin
         boostState_reg <= boostState_next;
      end
   end

   assign boostOn = (boostState_reg == BOOST_ACTIVE);

   // Limit errors set on crossing and clear once back inside by the zone hysteresis, or at once while the high limit is 80h.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         highErr_reg <= 1'b0;
         lowErr_reg <= 1'b0;
      end else begin
         if (highLimit == `FBZ_HIGH_MASK) begin
            highErr_reg <= 1'b0;
         end else if (tempW > highW) begin
            highErr_reg <= 1'b1;
         end else if ((tempW + lHystW) <= highW) begin
            highErr_reg <= 1'b0;
         end
         if (highLimit == `FBZ_HIGH_MASK) begin
            lowErr_reg <= 1'b0;
         end else if (tempW < lowW) begin
            lowErr_reg <= 1'b1;
         end else if (tempW >= (lowW + lHystW)) begin
            lowErr_reg <= 1'b0;
         end
      end
   end

endmodule

// *** logic/fbz_boost_top.v ***
// Fan boost, limit hysteresis and zone 1b/2b offset trim with its register port.
//
// Summary of operation
// - A zone hotter than its boost threshold drives both fan PWM outputs to full duty.
// - An active boost beats the coarse manual duty override.
// - The fine manual duty override beats the boost.
// - A threshold of 7Fh at 1 degree fan resolution never raises a boost for that zone.
// - A threshold of 80h disables boost for that zone entirely.
// - Boost holds until the zone falls below its threshold by the boost hysteresis or the threshold is set to a disable code.
// - Boost thresholds reset to 3Ch for zones 1 and 2 and to 23h for zones 3 and 4.
// - The zones 1/2 hysteresis register holds zone 1 in bits 3:0 and zone 2 in bits 7:4.
// - The zones 3/4 hysteresis register holds zone 3 in bits 3:0 and zone 4 in bits 7:4.
// - Each limit hysteresis field is unsigned 0 to 15 degrees and resets to zero.
// - A 6-bit signed trim is added to every zone 1b and zone 2b measurement as taken.
// - Readings, limit checks and fan control all use the trimmed zone 1b and 2b values.
`timescale 1ns/100ps
`include "fbz_consts.vh"

module fbz_boost_top (
   input wire clk,
   input wire rst_n,
   input wire [7:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWrEn,
   input wire regRdEn,
   output reg [7:0] regRdData_reg,
   output reg regRdHit_reg,
   input wire [7:0] zone1bRaw,
   input wire zone1bValid,
   input wire [7:0] zone2bRaw,
   input wire zone2bValid,
   input wire [7:0] zone3Temp,
   input wire [7:0] zone4Temp,
   input wire [31:0] lowLimits,
   input wire [31:0] highLimits,
   input wire [15:0] boostHysts,
   input wire fanRes1C,
   input wire [7:0] pwm1Auto,
   input wire [7:0] pwm2Auto,
   input wire coarseManEn,
   input wire [7:0] pwm1Coarse,
   input wire [7:0] pwm2Coarse,
   input wire fineManEn,
   input wire [7:0] pwm1Fine,
   input wire [7:0] pwm2Fine,
   output reg [7:0] zone1bTemp_reg,
   output reg [7:0] zone2bTemp_reg,
   output reg [3:0] highErrs_reg,
   output reg [3:0] lowErrs_reg,
   output reg [3:0] zoneBoost_reg,
   output reg boostActive_reg,
   output reg [7:0] pwm1Out_reg,
   output reg [7:0] pwm2Out_reg
);

   // Reset release pair; rstSyncN is the copy that the rest of the block uses.
   reg rstMeta_reg;
   reg rstSyncN;

   // Host-visible boost thresholds, one per zone.
   reg [7:0] boostThr1_reg;
   reg [7:0] boostThr2_reg;
   reg [7:0] boostThr3_reg;
   reg [7:0] boostThr4_reg;

   // Shared limit hysteresis registers, two zone fields per byte.
   reg [7:0] hystZ12_reg;
   reg [7:0] hystZ34_reg;

   // Signed offset trims for the zone 1b and 2b readings.
   reg [5:0] zoneOneBOffset_reg;
   reg [5:0] zoneTwoBOffset_reg;

   // Next values of the read port and of the duty outputs.
   reg [7:0] rdData_next;
   reg rdHit_next;
   reg [7:0] pwm1_next;
   reg [7:0] pwm2_next;

   // Per-zone bundles fed to the conditioning slices, zone 1 in the low bits.
   wire [31:0] zoneTemps;
   wire [31:0] boostThrs;
   wire [15:0] limitHysts;

   // Per-zone results coming back from the slices.
   wire [3:0] zoneBoost;
   wire [3:0] zoneHigh;
   wire [3:0] zoneLow;
   wire anyBoost;

   // Limit hysteresis fields unpacked from the shared registers.
   wire [3:0] zoneOneHyst;
   wire [3:0] zoneTwoHyst;
   wire [3:0] zoneThreeHyst;
   wire [3:0] zoneFourHyst;

   // Adds a signed trim to a signed reading and clamps to the 8-bit range instead of wrapping.
   function [7:0] trim_add;
      input [7:0] raw;
      input [5:0] trim;
      reg signed [8:0] sum;
      begin
         sum = $signed({raw[7], raw}) + $signed({{3{trim[5]}}, trim});
         if (sum > $signed({1'b0, `FBZ_TEMP_MAX})) begin
            trim_add = `FBZ_TEMP_MAX;
         end else if (sum < $signed({1'b1, `FBZ_TEMP_MIN})) begin
            trim_add = `FBZ_TEMP_MIN;
         end else begin
            trim_add = sum[7:0];
         end
      end
   endfunction

   // Reset release through two flip-flops; all other logic uses the released copy.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_reg <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSyncN <= rstMeta_reg;
      end
   end

   // Boost threshold writes from the serial interface engine.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         boostThr1_reg <= `FBZ_RST_BOOST_Z12;
         boostThr2_reg <= `FBZ_RST_BOOST_Z12;
         boostThr3_reg <= `FBZ_RST_BOOST_Z34;
         boostThr4_reg <= `FBZ_RST_BOOST_Z34;
      end else if (regWrEn) begin
         case (regAddr)
            `FBZ_ADDR_BOOST_Z1: begin
               boostThr1_reg <= regWrData;
            end
            `FBZ_ADDR_BOOST_Z2: begin
               boostThr2_reg <= regWrData;
            end
            `FBZ_ADDR_BOOST_Z3: begin
               boostThr3_reg <= regWrData;
            end
            `FBZ_ADDR_BOOST_Z4: begin
               boostThr4_reg <= regWrData;
            end
            default: begin
               boostThr1_reg <= boostThr1_reg;
            end
         endcase
      end
   end

   // Limit hysteresis writes; each byte carries the fields of two zones.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         hystZ12_reg <= `FBZ_RST_HYST;
         hystZ34_reg <= `FBZ_RST_HYST;
      end else if (regWrEn) begin
         case (regAddr)
            `FBZ_ADDR_HYST_Z12: begin
               hystZ12_reg <= regWrData;
            end
            `FBZ_ADDR_HYST_Z34: begin
               hystZ34_reg <= regWrData;
            end
            default: begin
               hystZ12_reg <= hystZ12_reg;
            end
         endcase
      end
   end

   // Trim writes; the two reserved top bits of the byte are dropped on purpose.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         zoneOneBOffset_reg <= `FBZ_RST_TRIM;
         zoneTwoBOffset_reg <= `FBZ_RST_TRIM;
      end else if (regWrEn) begin
         case (regAddr)
            `FBZ_ADDR_TRIM_Z1B: begin
               zoneOneBOffset_reg <= regWrData[`FBZ_TRIM_MSB:0];
            end
            `FBZ_ADDR_TRIM_Z2B: begin
               zoneTwoBOffset_reg <= regWrData[`FBZ_TRIM_MSB:0];
            end
            default: begin
               zoneOneBOffset_reg <= zoneOneBOffset_reg;
            end
         endcase
      end
   end

   // Read mux; trim registers show their reserved top bits as zero.
   always @* begin
      rdData_next = `FBZ_READ_NONE;
      rdHit_next = 1'b1;
      case (regAddr)
         `FBZ_ADDR_BOOST_Z1: begin
            rdData_next = boostThr1_reg;
         end
         `FBZ_ADDR_BOOST_Z2: begin
            rdData_next = boostThr2_reg;
         end
         `FBZ_ADDR_BOOST_Z3: begin
            rdData_next = boostThr3_reg;
         end
         `FBZ_ADDR_BOOST_Z4: begin
            rdData_next = boostThr4_reg;
         end
         `FBZ_ADDR_HYST_Z12: begin
            rdData_next = hystZ12_reg;
         end
         `FBZ_ADDR_HYST_Z34: begin
            rdData_next = hystZ34_reg;
         end
         `FBZ_ADDR_TRIM_Z1B: begin
            rdData_next = {2'b00, zoneOneBOffset_reg};
         end
         `FBZ_ADDR_TRIM_Z2B: begin
            rdData_next = {2'b00, zoneTwoBOffset_reg};
         end
         default: begin
            rdHit_next = 1'b0;
         end
      endcase
   end

   // Read data is captured on the read strobe and held until the next one.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         regRdData_reg <= `FBZ_READ_NONE;
         regRdHit_reg <= 1'b0;
      end else if (regRdEn) begin
         regRdData_reg <= rdData_next;
         regRdHit_reg <= rdHit_next;
      end
   end

   // Zone 1b reading, trimmed once as each measurement lands.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         zone1bTemp_reg <= `FBZ_RST_TEMP;
      end else if (zone1bValid) begin
         zone1bTemp_reg <= trim_add(zone1bRaw, zoneOneBOffset_reg);
      end
   end

   // Zone 2b reading, trimmed the same way so both zones behave alike.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         zone2bTemp_reg <= `FBZ_RST_TEMP;
      end else if (zone2bValid) begin
         zone2bTemp_reg <= trim_add(zone2bRaw, zoneTwoBOffset_reg);
      end
   end

   // Hysteresis fields unpacked from the two shared registers.
   assign zoneOneHyst = hystZ12_reg[`FBZ_HYST_LO_MSB:`FBZ_HYST_LO_LSB];
   assign zoneTwoHyst = hystZ12_reg[`FBZ_HYST_HI_MSB:`FBZ_HYST_HI_LSB];
   assign zoneThreeHyst = hystZ34_reg[`FBZ_HYST_LO_MSB:`FBZ_HYST_LO_LSB];
   assign zoneFourHyst = hystZ34_reg[`FBZ_HYST_HI_MSB:`FBZ_HYST_HI_LSB];

   // Zones 1 and 2 are fed only by the trimmed readings, never by the raw ones.
   assign zoneTemps = {zone4Temp, zone3Temp, zone2bTemp_reg, zone1bTemp_reg};
   assign boostThrs = {boostThr4_reg, boostThr3_reg, boostThr2_reg, boostThr1_reg};
   assign limitHysts = {zoneFourHyst, zoneThreeHyst, zoneTwoHyst, zoneOneHyst};

   // One conditioning slice per zone.
   genvar z;
   generate
      for (z = 0; z < 4; z = z + 1) begin : gZone
         fbz_zone_cond uCond (
            .clk(clk),
            .rstSyncN(rstSyncN),
            .zoneTemp(zoneTemps[8*z+7:8*z]),
            .boostThr(boostThrs[8*z+7:8*z]),
            .boostHyst(boostHysts[4*z+3:4*z]),
            .limitHyst(limitHysts[4*z+3:4*z]),
            .lowLimit(lowLimits[8*z+7:8*z]),
            .highLimit(highLimits[8*z+7:8*z]),
            .fanRes1C(fanRes1C),
            .boostOn(zoneBoost[z]),
            .highErr_reg(zoneHigh[z]),
            .lowErr_reg(zoneLow[z])
         );
      end
   endgenerate

   // Any single zone in boost is enough to force full duty on both outputs.
   assign anyBoost = |zoneBoost;

   // Duty priority: fine manual, then boost, then coarse manual, then automatic control.
   always @* begin
      pwm1_next = pwm1Auto;
      pwm2_next = pwm2Auto;
      if (fineManEn) begin
         pwm1_next = pwm1Fine;
         pwm2_next = pwm2Fine;
      end else if (anyBoost) begin
         pwm1_next = `FBZ_FULL_DUTY;
         pwm2_next = `FBZ_FULL_DUTY;
      end else if (coarseManEn) begin
         pwm1_next = pwm1Coarse;
         pwm2_next = pwm2Coarse;
      end
   end

   // Duty output flip-flops.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         pwm1Out_reg <= `FBZ_RST_DUTY;
         pwm2Out_reg <= `FBZ_RST_DUTY;
      end else begin
         pwm1Out_reg <= pwm1_next;
         pwm2Out_reg <= pwm2_next;
      end
   end

   // Boost status flip-flops, kept in step with the duty outputs.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         boostActive_reg <= 1'b0;
         zoneBoost_reg <= 4'h0;
      end else begin
         boostActive_reg <= anyBoost;
         zoneBoost_reg <= zoneBoost;
      end
   end

   // Limit error status flip-flops.
   always @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         highErrs_reg <= 4'h0;
         lowErrs_reg <= 4'h0;
      end else begin
         highErrs_reg <= zoneHigh;
         lowErrs_reg <= zoneLow;
      end
   end

endmodule

// *** test/fbz_boost_assertions.sv ***
// Port checks for the fan boost block.
`timescale 1ns/100ps
`include "fbz_consts.vh"
module fbz_boost_assertions (
   input logic clk,
   input logic rst_n,
   input logic [7:0] regAddr,
   input logic regRdEn,
   input logic [7:0] regRdData_reg,
   input logic regRdHit_reg,
   input logic [7:0] zone4Temp,
   input logic [31:0] lowLimits,
   input logic [31:0] highLimits,
   input logic coarseManEn,
   input logic fineManEn,
   input logic [7:0] pwm1Auto,
   input logic [7:0] pwm1Coarse,
   input logic [7:0] pwm1Fine,
   input logic [3:0] zoneBoost_reg,
   input logic [3:0] highErrs_reg,
   input logic [3:0] lowErrs_reg,
   input logic boostActive_reg,
   input logic [7:0] pwm1Out_reg,
   input logic [7:0] pwm2Out_reg
);
   logic [2:0] up_reg;
   // Decodes and zone 4 limit conditions used below.
   wire ready = up_reg == 3'h7;
   wire mapped = regAddr[7:4] == 4'h8 && (regAddr[3:0] < 4'h6 || regAddr[3:0] > 4'hD);
   wire mask4 = highLimits[31:24] == `FBZ_HIGH_MASK;
   wire hiOver = !mask4 && $signed(zone4Temp) > $signed(highLimits[31:24]);
   wire loUnder = !mask4 && $signed(zone4Temp) < $signed(lowLimits[31:24]);
   // Counts edges after reset so the internal reset copy has let go.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_reg <= 3'h0;
      end else if (!ready) begin
         up_reg <= up_reg + 3'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   fine_wins_a: assert property (ready && fineManEn |=> pwm1Out_reg == $past(pwm1Fine))
      else $error("fine duty not driven");
   boost_full_a: assert property (ready && boostActive_reg && !$past(fineManEn)
      |-> pwm1Out_reg == `FBZ_FULL_DUTY && pwm2Out_reg == `FBZ_FULL_DUTY)
      else $error("boost without full duty");
   coarse_duty_a: assert property (ready && !boostActive_reg && !$past(fineManEn)
      && $past(coarseManEn) |-> pwm1Out_reg == $past(pwm1Coarse))
      else $error("coarse duty wrong");
   auto_duty_a: assert property (ready && !boostActive_reg && !$past(fineManEn)
      && !$past(coarseManEn) |-> pwm1Out_reg == $past(pwm1Auto))
      else $error("normal duty wrong");
   boost_or_a: assert property (ready |-> boostActive_reg == |zoneBoost_reg)
      else $error("boost summary wrong");
   read_decode_a: assert property (ready && regRdEn
      |=> regRdHit_reg == $past(mapped) && (regRdHit_reg || regRdData_reg == 8'h00))
      else $error("read decode wrong");
   high_mask_a: assert property ((ready && mask4) ##1 mask4
      |=> !highErrs_reg[3] && !lowErrs_reg[3])
      else $error("masked zone shows error");
   high_set_a: assert property ((ready && hiOver) ##1 !mask4 |=> highErrs_reg[3])
      else $error("high error not set");
   low_set_a: assert property ((ready && loUnder) ##1 !mask4 |=> lowErrs_reg[3])
      else $error("low error not set");
endmodule

// *** test/fbz_host_model.sv ***
// Serial engine side model issuing register writes and reads.
`timescale 1ns/100ps
module fbz_host_model (
   input logic clk,
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   output logic regWrEn,
   output logic regRdEn,
   input logic [7:0] regRdData_reg
);
   // Idle lines at time zero.
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   // One write taken at the next edge; released lines then show other values.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(posedge clk);
      #2;
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
      @(posedge clk);
      #2;
   endtask
   // One read; the data stands from the taking edge and is sampled one edge later.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      regAddr = a;
      regRdEn = 1'b1;
      @(posedge clk);
      #2;
      regRdEn = 1'b0;
      regAddr = ~a;
      @(posedge clk);
      #2;
      d = regRdData_reg;
   endtask
endmodule

// *** test/fbz_boost_top_bench.sv ***
// Self-checking bench for the fan boost block.
`timescale 1ns/100ps
module fbz_boost_top_bench;
   logic clk, rst_n, zone1bValid, zone2bValid, fanRes1C, coarseManEn, fineManEn;
   logic regWrEn, regRdEn, regRdHit_reg, boostActive_reg;
   logic [7:0] zone1bRaw, zone2bRaw, zone3Temp, zone4Temp, pwm1Auto, pwm2Auto, rv, wd;
   logic [7:0] pwm1Coarse, pwm2Coarse, pwm1Fine, pwm2Fine, regAddr, regWrData;
   logic [7:0] regRdData_reg, zone1bTemp_reg, zone2bTemp_reg, pwm1Out_reg, pwm2Out_reg;
   logic [31:0] lowLimits, highLimits;
   logic [15:0] boostHysts;
   logic [3:0] highErrs_reg, lowErrs_reg, zoneBoost_reg;
   logic [5:0] tr;
   int failures, checks, i;
   logic [7:0] adr [8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h8E, 8'h8F};
   logic [7:0] rstv [8] = '{8'h3C, 8'h3C, 8'h23, 8'h23, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] tmp [6] = '{8'h41, 8'h3E, 8'h3D, 8'h05, 8'h12, 8'h13};
   logic [3:0] hiE [6] = '{4'h8, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0};
   logic [3:0] loE [6] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h8, 4'h0};
   logic [7:0] cd [3] = '{8'h80, 8'h7F, 8'h7F};
   logic [3:0] zb [3] = '{4'h0, 4'h0, 4'h4};
   fbz_boost_top DUT (.clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn,
      .regRdData_reg, .regRdHit_reg, .zone1bRaw, .zone1bValid, .zone2bRaw, .zone2bValid,
      .zone3Temp, .zone4Temp, .lowLimits, .highLimits, .boostHysts, .fanRes1C, .pwm1Auto,
      .pwm2Auto, .coarseManEn, .pwm1Coarse, .pwm2Coarse, .fineManEn, .pwm1Fine, .pwm2Fine,
      .zone1bTemp_reg, .zone2bTemp_reg, .highErrs_reg, .lowErrs_reg, .zoneBoost_reg,
      .boostActive_reg, .pwm1Out_reg, .pwm2Out_reg);
   fbz_host_model host (.clk, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData_reg);
   // Compares one value and counts the result.
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic h);
      host.rd(a, rv);
      chk("read data", rv, e);
      chk("read hit", {7'h00, regRdHit_reg}, {7'h00, h});
   endtask
   // One measurement pulse on zone 1b or 2b; raw lines change once it is taken.
   task automatic meas(input logic [7:0] r, input logic z);
      zone1bRaw = r;
      zone2bRaw = r;
      zone1bValid = !z;
      zone2bValid = z;
      tick(1);
      zone1bValid = 1'b0;
      zone2bValid = 1'b0;
      zone1bRaw = ~r;
      zone2bRaw = ~r;
   endtask
   // Trimmed reading with saturation at the signed byte range.
   function automatic logic [7:0] sat(input logic [7:0] r, input logic [5:0] t);
      int s;
      s = $signed(r) + $signed(t);
      if (s > 127) s = 127;
      if (s < -128) s = -128;
      return s[7:0];
   endfunction
   task automatic final_report();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Cuts a hang short.
   initial begin
      #500000;
      failures++;
      final_report();
   end
   // Main sequence.
   initial begin
      {rst_n, zone1bValid, zone2bValid, fanRes1C, coarseManEn, fineManEn} = 6'h00;
      {zone1bRaw, zone2bRaw, zone3Temp, zone4Temp} = 32'h00000000;
      {lowLimits, highLimits, boostHysts} = {32'h80808080, 32'h80808080, 16'h0000};
      void'($urandom(32'hD3BB9819));
      {pwm1Auto, pwm2Auto, pwm1Coarse, pwm2Coarse} = 32'($urandom);
      {pwm1Fine, pwm2Fine} = 16'($urandom);
      repeat (12) @(posedge clk);
      #2;
      rst_n = 1'b1;
      tick(4);
      for (i = 0; i < 8; i++) begin
         rdchk(adr[i], rstv[i], 1'b1);
      end
      rdchk(8'h86, 8'h00, 1'b0);
      for (i = 0; i < 8; i++) begin
         wd = 8'($urandom);
         host.wr(adr[i], wd);
         rdchk(adr[i], i > 5 ? {2'b00, wd[5:0]} : wd, 1'b1);
      end
      for (i = 0; i < 4; i++) begin
         host.wr(adr[i], 8'h70);
      end
      boostHysts = 16'h0400;
      host.wr(8'h82, 8'h30);
      zone3Temp = 8'h31;
      tick(3);
      chk("pwm1 boost", pwm1Out_reg, 8'hFF);
      chk("pwm2 boost", pwm2Out_reg, 8'hFF);
      chk("boost flag", {7'h00, boostActive_reg}, 8'h01);
      coarseManEn = 1'b1;
      tick(3);
      chk("coarse boost", pwm1Out_reg, 8'hFF);
      fineManEn = 1'b1;
      tick(3);
      chk("fine boost", pwm2Out_reg, pwm2Fine);
      fineManEn = 1'b0;
      zone3Temp = 8'h2C;
      tick(3);
      chk("hold boost", pwm1Out_reg, 8'hFF);
      zone3Temp = 8'h2B;
      tick(3);
      chk("coarse duty", pwm2Out_reg, pwm2Coarse);
      coarseManEn = 1'b0;
      tick(3);
      chk("auto duty", pwm1Out_reg, pwm1Auto);
      chk("boost clear", {7'h00, boostActive_reg}, 8'h00);
      boostHysts = 16'h0000;
      zone3Temp = 8'h7F;
      for (i = 0; i < 3; i++) begin
         fanRes1C = 1'b0;
         host.wr(8'h82, 8'h10);
         tick(3);
         chk("boost set", {4'h0, zoneBoost_reg}, 8'h04);
         fanRes1C = (i == 1);
         host.wr(8'h82, cd[i]);
         tick(3);
         chk("boost code", {4'h0, zoneBoost_reg}, {4'h0, zb[i]});
      end
      zone3Temp = 8'h00;
      fanRes1C = 1'b0;
      host.wr(8'h82, 8'h70);
      for (i = 0; i < 10; i++) begin
         tr = i == 0 ? 6'h1F : i == 1 ? 6'h20 : 6'($urandom);
         wd = i == 0 ? 8'h7C : i == 1 ? 8'h82 : 8'($urandom);
         host.wr(8'h8E + {7'h00, i[0]}, {2'b00, tr});
         meas(wd, i[0]);
         chk("trim", i[0] ? zone2bTemp_reg : zone1bTemp_reg, sat(wd, tr));
      end
      host.wr(8'h80, 8'h3C);
      meas(8'h00, 1'b0);
      for (i = 0; i < 2; i++) begin
         host.wr(8'h8E, 8'(i));
         meas(8'h3C, 1'b0);
         tick(3);
         chk("trimmed boost", {7'h00, zoneBoost_reg[0]}, 8'(i));
      end
      host.wr(8'h85, 8'h30);
      {lowLimits, highLimits} = {32'h10808080, 32'h40808080};
      for (i = 0; i < 6; i++) begin
         zone4Temp = tmp[i];
         tick(3);
         chk("high err", {4'h0, highErrs_reg}, {4'h0, hiE[i]});
         chk("low err", {4'h0, lowErrs_reg}, {4'h0, loE[i]});
      end
      final_report();
   end
endmodule
bind fbz_boost_top fbz_boost_assertions watch (.clk, .rst_n, .regAddr, .regRdEn,
   .regRdData_reg, .regRdHit_reg, .zone4Temp, .lowLimits, .highLimits, .coarseManEn,
   .fineManEn, .pwm1Auto, .pwm1Coarse, .pwm1Fine, .zoneBoost_reg, .highErrs_reg,
   .lowErrs_reg, .boostActive_reg, .pwm1Out_reg, .pwm2Out_reg);
